// ===== hdl/igcr_global_ctrl.sv
// Global control register zero with its bypass and fault policy decode
`timescale 1ns/1ps
// Function
// - VMID width select, reserved if unsupported
// - Hypervisor context type select bit
// - Write allocate hint for bypass traffic
// - Read allocate hint for bypass traffic
// - Shareability override for bypass traffic
// - Multi-match: bypass or conflict fault
// - Memory type override from attribute field
// - Barrier minimum shareability upgrade
// - Force maintenance broadcast to inner domain
// - Private TLB maintenance hint
// - Private VMID namespace hint
// - No match: pass or unidentified fault
// - Global stall enable, writable if supported
// - Stall disable kills stalls, masks global stall
// - Transient hint for bypass traffic
// - Config fault raises interrupt when enabled
// - Config fault returns abort when enabled
// - Extended stream ID format select
// - Global fault interrupt and abort enables
// - Client bypass all, resets to one
module igcr_global_ctrl #(
  parameter bit HAS_WIDE_VMID = 1'b1,
  parameter bit HAS_HYP_EXT = 1'b1,
  parameter bit HAS_ALLOC_CFG = 1'b1,
  parameter bit HAS_SH_CFG = 1'b1,
  parameter bit SMCF_CONFIGURABLE = 1'b1,
  parameter bit SMCF_FIXED_VAL = 1'b0,
  parameter bit HAS_BSU = 1'b1,
  parameter bit HAS_BCAST_TLB = 1'b1,
  parameter bit HAS_GLOBAL_STALL = 1'b1,
  parameter bit HAS_TRANSIENT = 1'b1,
  parameter bit HAS_CFG_FAULT = 1'b1,
  parameter bit HAS_EXT_ID = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [igcr_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Client transaction classification
  input wire logic txn_valid,
  input wire logic txn_no_match,
  input wire logic txn_multi_match,
  input wire logic txn_is_maint,
  input wire logic txn_is_barrier,
  input wire logic global_fault,
  input wire logic config_fault,
  input wire logic ctx_fault,
  input wire logic bcast_tlbi,
  input wire logic bcast_tlbi_has_vmid,
  input wire logic [1:0] cb_type,
  // Decoded policy outputs
  output logic txn_bypass,
  output logic txn_fault,
  output logic [1:0] txn_fault_cause,
  output logic [1:0] wr_alloc_out,
  output logic [1:0] rd_alloc_out,
  output logic [1:0] share_out,
  output logic [1:0] transient_out,
  output logic mem_attr_override,
  output logic [3:0] mem_attr_out,
  output logic [1:0] barrier_domain_out,
  output logic maint_broadcast,
  output logic tlbi_apply,
  output logic ctx_stall,
  output logic global_stall,
  output logic wide_vm_id_enable,
  output logic host_extension_hyp_context,
  output logic extended_stream_id_en,
  output logic fault_irq,
  output logic fault_abort
);

  typedef struct packed {
    logic [31:0] gc0;
    logic [31:0] rdata;
    logic bypass;
    logic fault;
    logic [1:0] cause;
    logic [1:0] wa;
    logic [1:0] ra;
    logic [1:0] sh;
    logic [1:0] tr;
    logic mt;
    logic [3:0] ma;
    logic [1:0] bd;
    logic bcast;
    logic tlbi;
    logic cstall;
    logic gstall;
    logic wide;
    logic e2h;
    logic exid;
    logic irq;
    logic abort;
    logic [1:0] sticky;
  } igcr_state_t;

  igcr_state_t s_q, s_d;
  logic [31:0] wmask;
  logic [31:0] ro_val;
  logic [31:0] view;
  logic stall_disable;

  // Writable bit mask from implemented features
  always_comb begin
    wmask = 32'h0000_0000;
    ro_val = 32'h0000_0000;
    wmask[igcr_pkg::B_WIDE_VMID] = HAS_WIDE_VMID;
    wmask[igcr_pkg::B_HYP_SEL] = HAS_HYP_EXT;
    wmask[igcr_pkg::B_WA_LO +: 2] = {2{HAS_ALLOC_CFG}};
    wmask[igcr_pkg::B_RA_LO +: 2] = {2{HAS_ALLOC_CFG}};
    wmask[igcr_pkg::B_SH_LO +: 2] = {2{HAS_SH_CFG}};
    // may be fixed and ignore writes
    wmask[igcr_pkg::B_SMCF] = SMCF_CONFIGURABLE;
    ro_val[igcr_pkg::B_SMCF] = SMCF_CONFIGURABLE ? 1'b0 : SMCF_FIXED_VAL;
    wmask[igcr_pkg::B_MT_EN] = 1'b1;
    wmask[igcr_pkg::B_MA_LO +: 4] = 4'hf;
    // reads zero when topology lacks it
    wmask[igcr_pkg::B_BSU_LO +: 2] = {2{HAS_BSU}};
    wmask[igcr_pkg::B_FB] = 1'b1;
    wmask[igcr_pkg::B_PTM] = HAS_BCAST_TLB;
    ro_val[igcr_pkg::B_PTM] = ~HAS_BCAST_TLB;
    wmask[igcr_pkg::B_VMPNE] = 1'b1;
    wmask[igcr_pkg::B_USF] = 1'b1;
    wmask[igcr_pkg::B_GSE] = HAS_GLOBAL_STALL;
    wmask[igcr_pkg::B_STALL_DISABLE] = 1'b1;
    wmask[igcr_pkg::B_TR_LO +: 2] = {2{HAS_TRANSIENT}};
    wmask[igcr_pkg::B_CFIE] = HAS_CFG_FAULT;
    wmask[igcr_pkg::B_CFRE] = HAS_CFG_FAULT;
    wmask[igcr_pkg::B_EXID] = HAS_EXT_ID;
    wmask[igcr_pkg::B_GLOBAL_FAULT_IRQ_EN] = 1'b1;
    wmask[igcr_pkg::B_GLOBAL_FAULT_ABORT_EN] = 1'b1;
    wmask[igcr_pkg::B_BYP] = 1'b1;
  end

  // Software-visible view; stall disable masks the global stall bit
  always_comb begin
    stall_disable = s_q.gc0[igcr_pkg::B_STALL_DISABLE];
    view = (s_q.gc0 & wmask) | (ro_val & ~wmask);
    if (stall_disable) begin
      view[igcr_pkg::B_GSE] = 1'b0;
    end
  end

  // Next state: register access and policy decode
  always_comb begin
    s_d = s_q;
    // Writes update only implemented bits
    if (reg_wr && reg_addr == igcr_pkg::GC0_ADDR) begin
      s_d.gc0 = (reg_wdata & wmask) | (s_q.gc0 & ~wmask);
      if (stall_disable || reg_wdata[igcr_pkg::B_STALL_DISABLE]) begin
        s_d.gc0[igcr_pkg::B_GSE] = 1'b0;
      end
    end
    // Read data stands one cycle after the strobe, zero otherwise
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        igcr_pkg::GC0_ADDR: s_d.rdata = view;
        igcr_pkg::STAT_ADDR: s_d.rdata = {30'h0000_0000, s_q.sticky};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Fault seen history; an event wins over a clearing read
    if (reg_rd && reg_addr == igcr_pkg::STAT_ADDR) begin
      s_d.sticky = 2'h0;
    end
    s_d.sticky = s_d.sticky | {config_fault, global_fault};

    s_d.fault = 1'b0;
    s_d.cause = igcr_pkg::IGCR_F_NONE;
    s_d.bypass = 1'b0;
    if (txn_valid) begin
      if (view[igcr_pkg::B_BYP]) begin
        s_d.bypass = 1'b1;
      end else if (txn_multi_match) begin
        s_d.fault = view[igcr_pkg::B_SMCF];
        s_d.bypass = ~view[igcr_pkg::B_SMCF];
        s_d.cause = view[igcr_pkg::B_SMCF] ? igcr_pkg::IGCR_F_CONFLICT : igcr_pkg::IGCR_F_NONE;
      end else if (txn_no_match) begin
        s_d.fault = view[igcr_pkg::B_USF];
        s_d.bypass = ~view[igcr_pkg::B_USF];
        s_d.cause = view[igcr_pkg::B_USF] ? igcr_pkg::IGCR_F_UNID : igcr_pkg::IGCR_F_NONE;
      end
    end
    // Attribute overrides only for bypassing traffic; reserved code keeps default
    s_d.wa = igcr_pkg::HINT_DEFAULT;
    s_d.ra = igcr_pkg::HINT_DEFAULT;
    s_d.sh = igcr_pkg::HINT_DEFAULT;
    s_d.tr = igcr_pkg::HINT_DEFAULT;
    s_d.mt = 1'b0;
    s_d.ma = 4'h0;
    s_d.bd = 2'h0;
    s_d.bcast = 1'b0;
    if (s_d.bypass) begin
      if (view[igcr_pkg::B_WA_LO +: 2] != igcr_pkg::HINT_RSVD) s_d.wa = view[igcr_pkg::B_WA_LO +: 2];
      if (view[igcr_pkg::B_RA_LO +: 2] != igcr_pkg::HINT_RSVD) s_d.ra = view[igcr_pkg::B_RA_LO +: 2];
      s_d.sh = view[igcr_pkg::B_SH_LO +: 2];
      if (view[igcr_pkg::B_TR_LO +: 2] != igcr_pkg::HINT_RSVD) s_d.tr = view[igcr_pkg::B_TR_LO +: 2];
      s_d.mt = view[igcr_pkg::B_MT_EN];
      s_d.ma = view[igcr_pkg::B_MT_EN] ? view[igcr_pkg::B_MA_LO +: 4] : 4'h0;
      if (txn_is_barrier) s_d.bd = view[igcr_pkg::B_BSU_LO +: 2];
      s_d.bcast = txn_is_maint & view[igcr_pkg::B_FB];
    end
    // hints: private modes may skip system invalidates
    s_d.tlbi = bcast_tlbi & ~view[igcr_pkg::B_PTM] & ~(bcast_tlbi_has_vmid & view[igcr_pkg::B_VMPNE]);
    s_d.gstall = view[igcr_pkg::B_GSE];
    s_d.cstall = ctx_fault & ~stall_disable;
    s_d.wide = view[igcr_pkg::B_WIDE_VMID];
    // context bit meaning for hypervisor banks
    s_d.e2h = (cb_type == igcr_pkg::CB_TYPE_HYP) & view[igcr_pkg::B_HYP_SEL];
    s_d.exid = view[igcr_pkg::B_EXID];
    s_d.irq = (global_fault & view[igcr_pkg::B_GLOBAL_FAULT_IRQ_EN]) | (config_fault & view[igcr_pkg::B_CFIE]);
    s_d.abort = (global_fault & view[igcr_pkg::B_GLOBAL_FAULT_ABORT_EN]) | (config_fault & view[igcr_pkg::B_CFRE]);
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.gc0 <= igcr_pkg::GC0_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = s_q.rdata;
  assign txn_bypass = s_q.bypass;
  assign txn_fault = s_q.fault;
  assign txn_fault_cause = s_q.cause;
  assign wr_alloc_out = s_q.wa;
  assign rd_alloc_out = s_q.ra;
  assign share_out = s_q.sh;
  assign transient_out = s_q.tr;
  assign mem_attr_override = s_q.mt;
  assign mem_attr_out = s_q.ma;
  assign barrier_domain_out = s_q.bd;
  assign maint_broadcast = s_q.bcast;
  assign tlbi_apply = s_q.tlbi;
  assign ctx_stall = s_q.cstall;
  assign global_stall = s_q.gstall;
  assign wide_vm_id_enable = s_q.wide;
  assign host_extension_hyp_context = s_q.e2h;
  assign extended_stream_id_en = s_q.exid;
  assign fault_irq = s_q.irq;
  assign fault_abort = s_q.abort;

endmodule : igcr_global_ctrl

// ===== hdl/igcr_pkg.sv
// Package for the global control register zero block: layout, resets, encodings
package igcr_pkg;
  localparam int unsigned AW = 4;
  localparam logic [3:0] GC0_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  // Field positions
  localparam int unsigned B_WIDE_VMID = 31;
  localparam int unsigned B_HYP_SEL = 30;
  localparam int unsigned B_WA_LO = 26;
  localparam int unsigned B_RA_LO = 24;
  localparam int unsigned B_SH_LO = 22;
  localparam int unsigned B_SMCF = 21;
  localparam int unsigned B_MT_EN = 20;
  localparam int unsigned B_MA_LO = 16;
  localparam int unsigned B_BSU_LO = 14;
  localparam int unsigned B_FB = 13;
  localparam int unsigned B_PTM = 12;
  localparam int unsigned B_VMPNE = 11;
  localparam int unsigned B_USF = 10;
  localparam int unsigned B_GSE = 9;
  localparam int unsigned B_STALL_DISABLE = 8;
  localparam int unsigned B_TR_LO = 6;
  localparam int unsigned B_CFIE = 5;
  localparam int unsigned B_CFRE = 4;
  localparam int unsigned B_EXID = 3;
  localparam int unsigned B_GLOBAL_FAULT_IRQ_EN = 2;
  localparam int unsigned B_GLOBAL_FAULT_ABORT_EN = 1;
  localparam int unsigned B_BYP = 0;
  // Reset value: only client bypass set; unknown fields reset to zero here
  localparam logic [31:0] GC0_RESET = 32'h0000_0001;
  // Two-bit hint encodings
  localparam logic [1:0] HINT_DEFAULT = 2'h0;
  localparam logic [1:0] HINT_RSVD = 2'h1;
  localparam logic [1:0] HINT_FORCE = 2'h2;
  localparam logic [1:0] HINT_NOT = 2'h3;
  localparam logic [1:0] SH_OUTER = 2'h1;
  localparam logic [1:0] SH_INNER = 2'h2;
  localparam logic [1:0] SH_NONE = 2'h3;
  // Context bank type code that carries the hypervisor context bit
  localparam logic [1:0] CB_TYPE_HYP = 2'h1;
  // Fault cause encodings
  typedef enum logic [1:0] {IGCR_F_NONE, IGCR_F_UNID, IGCR_F_CONFLICT} igcr_fault_t;
endpackage : igcr_pkg

// ===== verif/igcr_client_model.sv
// Client master model issuing classified transactions
`timescale 1ns/1ps
module igcr_client_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [2:0] kind,
  output logic txn_valid,
  output logic txn_no_match,
  output logic txn_multi_match,
  output logic txn_is_maint,
  output logic txn_is_barrier
);
  // Idle qualifiers toggle, so only valid may give them meaning
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txn_valid <= 1'b0;
      {txn_no_match, txn_multi_match, txn_is_maint, txn_is_barrier} <= 4'h0;
    end else if (req) begin
      txn_valid <= 1'b1;
      {txn_is_maint, txn_multi_match, txn_no_match} <= kind;
      txn_is_barrier <= kind[2];
    end else begin
      txn_valid <= 1'b0;
      txn_no_match <= ~txn_no_match;
      txn_multi_match <= ~txn_multi_match;
      txn_is_maint <= ~txn_is_maint;
      txn_is_barrier <= ~txn_is_barrier;
    end
  end
endmodule : igcr_client_model

// ===== verif/igcr_global_ctrl_chk.sv
// Port checker for the global control register block
`timescale 1ns/1ps
module igcr_global_ctrl_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic txn_valid,
  input wire logic txn_no_match,
  input wire logic txn_multi_match,
  input wire logic global_fault,
  input wire logic config_fault,
  input wire logic [1:0] cb_type,
  input wire logic txn_bypass,
  input wire logic txn_fault,
  input wire logic [1:0] txn_fault_cause,
  input wire logic [1:0] wr_alloc_out,
  input wire logic [1:0] transient_out,
  input wire logic mem_attr_override,
  input wire logic [3:0] mem_attr_out,
  input wire logic host_extension_hyp_context,
  input wire logic fault_irq,
  input wire logic fault_abort
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Read data only in the cycle after a read
  read_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  fault_excl_a: assert property (txn_fault |-> !txn_bypass && $past(txn_valid)) else $error("fault with bypass");
  conflict_cause_a: assert property (txn_fault && $past(txn_multi_match) |-> txn_fault_cause == 2'h2)
    else $error("wrong conflict cause");
  unid_cause_a: assert property (txn_fault_cause == 2'h1 |-> txn_fault && $past(txn_no_match))
    else $error("wrong unmatched cause");
  hint_rsvd_a: assert property (wr_alloc_out != 2'h1 && transient_out != 2'h1) else $error("reserved hint out");
  attr_gate_a: assert property (mem_attr_out != 4'h0 |-> mem_attr_override) else $error("attr without override");
  irq_cause_a: assert property (fault_irq |-> $past(global_fault) || $past(config_fault)) else $error("stray irq");
  abort_cause_a: assert property ($rose(fault_abort) |-> $past(global_fault) || $past(config_fault))
    else $error("stray abort");
  hyp_type_a: assert property (host_extension_hyp_context |-> $past(cb_type) == 2'h1) else $error("hyp type");
  bypass_src_a: assert property (txn_bypass |-> $past(txn_valid)) else $error("bypass without txn");
endmodule : igcr_global_ctrl_chk
bind igcr_global_ctrl igcr_global_ctrl_chk igcr_global_ctrl_chk_i (.clk, .arst_n, .reg_rd, .reg_rdata,
  .txn_valid, .txn_no_match, .txn_multi_match, .global_fault, .config_fault, .cb_type, .txn_bypass, .txn_fault,
  .txn_fault_cause, .wr_alloc_out, .transient_out, .mem_attr_override, .mem_attr_out,
  .host_extension_hyp_context, .fault_irq, .fault_abort);

// ===== verif/tb_igcr_global_ctrl.sv
// Self-checking bench for the global control register block
`timescale 1ns/1ps
module tb_igcr_global_ctrl;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic req = 1'b0;
  logic [2:0] kind = 3'h0;
  logic global_fault = 1'b0;
  logic config_fault = 1'b0;
  logic [1:0] cb_type = 2'h0;
  logic ctx_fault = 1'b0;
  logic bcast_tlbi = 1'b0;
  logic bcast_tlbi_has_vmid = 1'b0;
  logic tlbi_apply, ctx_stall, global_stall;
  logic [1:0] barrier_domain_out;
  logic [31:0] reg_rdata;
  logic txn_valid, txn_no_match, txn_multi_match, txn_is_maint, txn_is_barrier, txn_bypass, txn_fault;
  logic mem_attr_override, maint_broadcast, host_extension_hyp_context, wide_vm_id_enable;
  logic extended_stream_id_en, fault_irq, fault_abort;
  logic [1:0] txn_fault_cause, wr_alloc_out, rd_alloc_out, share_out, transient_out;
  logic [3:0] mem_attr_out;
  int n_fail = 0;
  int comparisons = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  igcr_global_ctrl igcr_global_ctrl_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .txn_valid, .txn_no_match, .txn_multi_match, .txn_is_maint, .txn_is_barrier, .global_fault, .config_fault,
    .ctx_fault, .bcast_tlbi, .bcast_tlbi_has_vmid, .cb_type, .txn_bypass, .txn_fault,
    .txn_fault_cause, .wr_alloc_out, .rd_alloc_out, .share_out, .transient_out, .mem_attr_override,
    .mem_attr_out, .barrier_domain_out, .maint_broadcast, .tlbi_apply, .ctx_stall, .global_stall,
    .wide_vm_id_enable, .host_extension_hyp_context, .extended_stream_id_en, .fault_irq, .fault_abort);
  igcr_client_model igcr_client_model_i (.clk, .arst_n, .req, .kind, .txn_valid, .txn_no_match,
    .txn_multi_match, .txn_is_maint, .txn_is_barrier);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data is looked at only in its one valid cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic txn(input logic [2:0] k);
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
  endtask : txn
  task automatic pulse(input logic g);
    @(posedge clk);
    global_fault <= g;
    config_fault <= ~g;
    @(posedge clk);
    global_fault <= 1'b0;
    config_fault <= 1'b0;
    #1;
  endtask : pulse
  task automatic t_regs();
    rd(4'h0, 32'h0000_0001);
    rd(4'h8, 32'h0);
    wr(4'h0, 32'hffff_ffff);
    rd(4'h0, 32'hcfff_fdff);
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h0000_0200);
    rd(4'h0, 32'h0000_0200);
    wr(4'h0, 32'h0000_0300);
    rd(4'h0, 32'h0000_0100);
    $display("done regs");
  endtask : t_regs
  task automatic t_policy();
    wr(4'h0, 32'h0020_0400);
    txn(3'h1);
    chk({txn_bypass, txn_fault, txn_fault_cause}, 4'h5);
    txn(3'h3);
    chk({txn_bypass, txn_fault, txn_fault_cause}, 4'h6);
    wr(4'h0, 32'h0);
    txn(3'h2);
    chk({txn_bypass, txn_fault, txn_fault_cause}, 4'h8);
    txn(3'h1);
    chk({txn_bypass, txn_fault, txn_fault_cause}, 4'h8);
    txn(3'h0);
    chk({txn_bypass, txn_fault}, 2'h0);
    $display("done policy");
  endtask : t_policy
  task automatic t_hints();
    wr(4'h0, 32'h0b5a_e041);
    txn(3'h4);
    chk(barrier_domain_out, 2'h3);
    chk({wr_alloc_out, rd_alloc_out, share_out, transient_out}, 8'hb4);
    chk({mem_attr_override, mem_attr_out, maint_broadcast}, 6'h35);
    $display("done hints");
  endtask : t_hints
  task automatic t_faults();
    wr(4'h0, 32'h0000_0005);
    pulse(1'b1);
    chk({fault_irq, fault_abort}, 2'h2);
    pulse(1'b0);
    chk({fault_irq, fault_abort}, 2'h0);
    wr(4'h0, 32'h0000_0011);
    pulse(1'b0);
    chk({fault_irq, fault_abort}, 2'h1);
    pulse(1'b1);
    chk({fault_irq, fault_abort}, 2'h0);
    rd(4'h4, 32'h0000_0003);
    rd(4'h4, 32'h0000_0000);
    $display("done faults");
  endtask : t_faults
  task automatic t_ident();
    wr(4'h0, 32'hc000_0009); // nothing cached yet, no maintenance due
    cb_type <= 2'h1;
    repeat (2) @(posedge clk);
    #1;
    chk({wide_vm_id_enable, host_extension_hyp_context, extended_stream_id_en}, 3'h7);
    @(posedge clk);
    cb_type <= 2'h2;
    repeat (2) @(posedge clk);
    #1;
    chk(host_extension_hyp_context, 1'b0);
    $display("done ident");
  endtask : t_ident
  // Stall and broadcast invalidate policy
  task automatic t_stall();
    wr(4'h0, 32'h0000_0200);
    ctx_fault <= 1'b1;
    bcast_tlbi <= 1'b1;
    bcast_tlbi_has_vmid <= 1'b1;
    @(posedge clk);
    #1;
    chk({global_stall, ctx_stall, tlbi_apply}, 3'h7);
    wr(4'h0, 32'h0000_1900);
    @(posedge clk);
    #1;
    chk({global_stall, ctx_stall, tlbi_apply}, 3'h0);
    wr(4'h0, 32'h0000_0800);
    bcast_tlbi_has_vmid <= 1'b0;
    @(posedge clk);
    ctx_fault <= 1'b0;
    bcast_tlbi <= 1'b0;
    #1;
    chk({global_stall, ctx_stall, tlbi_apply}, 3'h3);
    $display("done stall");
  endtask : t_stall
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Watchdog well past the roughly 80 cycles the tests need
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_policy();
    t_hints();
    t_faults();
    t_ident();
    t_stall();
    print_verdict();
  end
endmodule : tb_igcr_global_ctrl
